// ==== rtl/cell_seq_pkg.sv ====
// shared constants, types and register map for the cell conversion sequencer
package cell_seq_pkg;
	// clock and timing
	localparam int CLK_MHZ = 50; // core clock rate
	localparam int ACQ_STEP_NS = 400; // acquire_time step and power-up value
	localparam int CONVERT_NS = 600; // convert_time, so one channel takes 1 us at the shortest acquire
	localparam int CHAN_MIN_NS = 1000; // least time per channel
	localparam int RESYNC_US = 5; // clock resync wait before results are readable
	localparam int SETTLE_US = 90; // mux reconfiguration settle after a control change
	localparam int HOP_NS = 200; // convert start hop delay between stacked devices
	// derived cycle counts, least times rounded up
	localparam int ACQ_STEP_CYC = (ACQ_STEP_NS * CLK_MHZ + 999) / 1000;
	localparam int CONVERT_CYC = (CONVERT_NS * CLK_MHZ + 999) / 1000;
	localparam int CHAN_MIN_CYC = (CHAN_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int RESYNC_CYC = RESYNC_US * CLK_MHZ;
	localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
	localparam int HOP_CYC = (HOP_NS * CLK_MHZ + 999) / 1000;
	// register byte offsets
	localparam logic [7:0] CONTROL_ADDR = 8'h00;
	localparam logic [7:0] STATUS_ADDR = 8'h04;
	localparam logic [7:0] CHAIN_ADDR = 8'h08;
	localparam logic [7:0] RESULT_BASE = 8'h10; // results at base + 4 * channel index
	localparam logic [7:0] RESULT_LAST = 8'h40; // self-test result slot
	// control field positions
	localparam int SEL_HI = 15;
	localparam int SEL_LO = 14;
	localparam int AVG_HI = 10;
	localparam int AVG_LO = 9;
	localparam int ACQ_HI = 6;
	localparam int ACQ_LO = 5;
	localparam int ARM_BIT = 1; // arms a start on the next chip-select rising edge
	// channel selection codes
	localparam logic [1:0] SEL_ALL = 2'h0;
	localparam logic [1:0] SEL_ODD_AUX = 2'h1;
	localparam logic [1:0] SEL_CELLS = 2'h2;
	localparam logic [1:0] SEL_SELFTEST = 2'h3;
	// channel indices: 0..5 cells 6..1, 6..11 aux 1..6, 12 self-test
	localparam logic [3:0] CH_FIRST = 4'h0;
	localparam logic [3:0] CH_LAST_CELL = 4'h5;
	localparam logic [3:0] CH_AUX1 = 4'h6;
	localparam logic [3:0] CH_AUX3 = 4'h8;
	localparam logic [3:0] CH_AUX5 = 4'ha;
	localparam logic [3:0] CH_LAST_AUX = 4'hb;
	localparam logic [3:0] CH_SELFTEST = 4'hc;
	localparam logic [3:0] CH_DONE = 4'hf;
	localparam int CHAIN_MAX = 8; // most stacked devices
	localparam logic [2:0] CHAIN_RESET = 3'h0; // devices above this one
	localparam logic [1:0] CODE_RESET = 2'h0; // power-up code of every control field
	// sequencer state
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ACQ = 2'b01,
		ST_CONV = 2'b10,
		ST_WAIT = 2'b11
	} state_t;
	// control register fields
	typedef struct packed {
		logic [1:0] sel;
		logic [1:0] avg;
		logic [1:0] acq;
		logic arm;
	} ctrl_t;
endpackage

// ==== rtl/cell_conversion_sequencer.sv ====
// conversion sequencer for a multiplexed cell and auxiliary input converter
// Behaviour
// [R1] two-bit select picks channel set or self-test
// [R2] cells descending from top, then aux ascending
// [R3] end of conversion advances mux, restarts next
// [R4] each channel takes at least one microsecond
// [R5] code 00 pin falling edge runs twelve
// [R6] code 10 runs six cells, no aux
// [R7] host waits 90 us after select change
// [R8] second control write starts at chip-select rise
// [R9] host waits 5 us before readback
// [R10] results readable once burst completes
// [R11] acquire field 400 to 1600 ns, resets 400
// [R12] average field one to eight, resets one
// [R13] all repeats of a channel done first
// [R14] averaged value stored like single result
// [R15] host waits 90 us after averaging change
// [R16] convert start forwarded up chain per hop
// [R17] chain holds at most eight devices
// [R18] count is inputs times averages, first acquire skipped
// [R19] last device starts within hops times slaves
// [R20] start during a burst is ignored
`timescale 1ns/100ps
module cell_conversion_sequencer #(
	parameter int SETTLE_CYCLES = cell_seq_pkg::SETTLE_CYC, // shorten in simulation
	parameter int HOP_CYCLES = cell_seq_pkg::HOP_CYC,
	parameter int DATA_W = 12 // converter resolution
) (
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	input wire logic CONV_START_N, // conv_start_n pin
	input wire logic CS_N, // serial chip select
	input wire logic CHAIN_START_IN, // start pulse from the device below
	output logic CHAIN_START_OUT, // start pulse to the device above
	input wire logic [DATA_W-1:0] ADC_DATA, // valid at the end of convert_time
	output logic [3:0] MUX_SEL,
	output logic ACQUIRE,
	output logic CONVERT,
	output logic BUSY,
	output logic READY,
	output logic SETTLING
);

	////////////////////////////////////////////////////////////////////////
	// functions

	// next channel of the burst for a selection code, CH_DONE at the end
	function automatic logic [3:0] next_chan(input logic [1:0] sel, input logic [3:0] ch);
		logic [3:0] nxt;
		nxt = cell_seq_pkg::CH_DONE;
		case (sel)
			cell_seq_pkg::SEL_ALL: begin
				if (ch < cell_seq_pkg::CH_LAST_AUX) nxt = ch + 4'h1; // see [R2]
			end
			cell_seq_pkg::SEL_ODD_AUX: begin
				if (ch < cell_seq_pkg::CH_AUX1) nxt = ch + 4'h1;
				else if (ch < cell_seq_pkg::CH_AUX5) nxt = ch + 4'h2; // aux 1, 3, 5
			end
			cell_seq_pkg::SEL_CELLS: begin
				if (ch < cell_seq_pkg::CH_LAST_CELL) nxt = ch + 4'h1; // see [R6]
			end
			default: begin
				nxt = cell_seq_pkg::CH_DONE; // self-test is one channel
			end
		endcase
		return nxt;
	endfunction

	// acquire_time in cycles for the two-bit code
	function automatic logic [15:0] acq_cycles(input logic [1:0] code);
		return 16'((int'(code) + 1) * cell_seq_pkg::ACQ_STEP_CYC); // see [R11]
	endfunction

	////////////////////////////////////////////////////////////////////////
	// declarations

	cell_seq_pkg::ctrl_t ctrl; // live configuration
	cell_seq_pkg::state_t state; // sequencer state
	logic [2:0] chain_above; // devices stacked above this one
	logic [15:0] timer; // phase timer
	logic [15:0] settle; // settle countdown after a control change
	logic [15:0] hop; // forwarding delay countdown
	logic [2:0] rep; // repeat index within a channel
	logic [DATA_W+2:0] accum; // running sum for averaging
	logic [DATA_W-1:0] result [0:12]; // one word per channel index
	logic pin_q; // previous pin level
	logic cs_q; // previous chip-select level
	logic start_req; // any start source this cycle
	logic start_take; // start accepted
	logic last_rep; // final repeat of this channel
	logic [DATA_W+2:0] sum; // accumulator plus new sample
	logic [3:0] nxt_ch; // next channel of the sequence
	logic [3:0] rd_idx; // result index from address
	logic wr_ctrl; // control register write

	////////////////////////////////////////////////////////////////////////
	// start detection

	// pin and chip select are synchronous; one flop each for edge detection
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			pin_q <= 1'b1;
			cs_q <= 1'b1;
		end else begin
			pin_q <= CONV_START_N;
			cs_q <= CS_N;
		end
	end

	always_comb begin
		// falling pin edge, armed chip-select rise, or a start from below
		start_req = (pin_q & ~CONV_START_N) | (~cs_q & CS_N & ctrl.arm) | CHAIN_START_IN; // see [R5] see [R8]
		start_take = start_req & (state == cell_seq_pkg::ST_IDLE); // see [R20]
		last_rep = (rep == 3'((1 << ctrl.avg) - 1));
		sum = accum + (DATA_W+3)'(ADC_DATA);
		nxt_ch = next_chan(ctrl.sel, MUX_SEL);
		wr_ctrl = WR & (ADDR == cell_seq_pkg::CONTROL_ADDR);
	end

	////////////////////////////////////////////////////////////////////////
	// control registers

	// fields reset to 400 ns acquire, no averaging, all channels
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ctrl.sel <= cell_seq_pkg::CODE_RESET;
			ctrl.avg <= cell_seq_pkg::CODE_RESET; // see [R12]
			ctrl.acq <= cell_seq_pkg::CODE_RESET; // see [R11]
			ctrl.arm <= 1'b0;
			chain_above <= cell_seq_pkg::CHAIN_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl.sel <= WDATA[cell_seq_pkg::SEL_HI:cell_seq_pkg::SEL_LO]; // see [R1]
				ctrl.avg <= WDATA[cell_seq_pkg::AVG_HI:cell_seq_pkg::AVG_LO];
				ctrl.acq <= WDATA[cell_seq_pkg::ACQ_HI:cell_seq_pkg::ACQ_LO];
				ctrl.arm <= WDATA[cell_seq_pkg::ARM_BIT]; // see [R8]
			end else if (start_take) begin
				ctrl.arm <= 1'b0; // one armed write gives one start
			end
			if (WR && ADDR == cell_seq_pkg::CHAIN_ADDR) begin
				chain_above <= WDATA[2:0]; // at most seven above, eight in all, see [R17]
			end
		end
	end

	// settle flag: the device only reports it; waiting is up to the host
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			settle <= 16'h0000;
			SETTLING <= 1'b0;
		end else if (wr_ctrl) begin
			settle <= 16'(SETTLE_CYCLES); // see [R7] see [R15]
			SETTLING <= 1'b1;
		end else if (settle != 16'h0000) begin
			settle <= settle - 16'h0001;
			SETTLING <= (settle != 16'h0001);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer

	// the mux rests on the top cell between bursts, so its acquisition is
	// already done and the first channel goes straight to conversion
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state <= cell_seq_pkg::ST_IDLE;
			timer <= 16'h0000;
			rep <= 3'h0;
			accum <= '0;
			MUX_SEL <= cell_seq_pkg::CH_FIRST;
			ACQUIRE <= 1'b1;
			CONVERT <= 1'b0;
			BUSY <= 1'b0;
			READY <= 1'b0;
		end else begin
			CONVERT <= 1'b0;
			case (state)
				cell_seq_pkg::ST_IDLE: begin
					if (start_take) begin
						BUSY <= 1'b1;
						READY <= 1'b0;
						rep <= 3'h0;
						accum <= '0;
						if (ctrl.sel == cell_seq_pkg::SEL_SELFTEST) begin
							// self-test input is not pre-acquired
							MUX_SEL <= cell_seq_pkg::CH_SELFTEST; // see [R1]
							timer <= acq_cycles(ctrl.acq) - 16'h0001;
							state <= cell_seq_pkg::ST_ACQ;
						end else begin
							ACQUIRE <= 1'b0; // first acquire skipped, see [R18]
							CONVERT <= 1'b1; // see [R5] see [R6]
							timer <= 16'(cell_seq_pkg::CONVERT_CYC - 1);
							state <= cell_seq_pkg::ST_CONV;
						end
					end
				end
				cell_seq_pkg::ST_ACQ: begin
					if (timer == 16'h0000) begin
						ACQUIRE <= 1'b0;
						CONVERT <= 1'b1; // see [R3]
						timer <= 16'(cell_seq_pkg::CONVERT_CYC - 1);
						state <= cell_seq_pkg::ST_CONV;
					end else begin
						timer <= timer - 16'h0001;
					end
				end
				cell_seq_pkg::ST_CONV: begin
					if (timer == 16'h0000) begin
						// end of conversion: sample, then repeat or advance
						timer <= acq_cycles(ctrl.acq) - 16'h0001; // acquire plus convert >= 1 us, see [R4]
						ACQUIRE <= 1'b1;
						if (!last_rep) begin
							accum <= sum;
							rep <= rep + 3'h1; // same channel again, see [R13]
							state <= cell_seq_pkg::ST_ACQ;
						end else begin
							accum <= '0;
							rep <= 3'h0;
							if (nxt_ch == cell_seq_pkg::CH_DONE) begin
								MUX_SEL <= cell_seq_pkg::CH_FIRST; // back to the top cell
								timer <= 16'(cell_seq_pkg::RESYNC_CYC - 1);
								state <= cell_seq_pkg::ST_WAIT;
							end else begin
								MUX_SEL <= nxt_ch; // see [R2] see [R3]
								state <= cell_seq_pkg::ST_ACQ;
							end
						end
					end else begin
						timer <= timer - 16'h0001;
					end
				end
				cell_seq_pkg::ST_WAIT: begin
					// results are released only after the resync wait
					if (timer == 16'h0000) begin
						BUSY <= 1'b0;
						READY <= 1'b1; // see [R10] see [R9]
						state <= cell_seq_pkg::ST_IDLE;
					end else begin
						timer <= timer - 16'h0001;
					end
				end
				default: begin
					state <= cell_seq_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// result store: the average is a shift, since counts are powers of two
	always_ff @(posedge CORE_CLK) begin
		if (state == cell_seq_pkg::ST_CONV && timer == 16'h0000 && last_rep) begin
			result[MUX_SEL] <= DATA_W'(sum >> ctrl.avg); // see [R14]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// daisy-chain forwarding

	// one hop delay per device; a start from below is forwarded the same way
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			hop <= 16'h0000;
			CHAIN_START_OUT <= 1'b0;
		end else begin
			CHAIN_START_OUT <= 1'b0;
			if (start_take && chain_above != 3'h0) begin
				hop <= 16'(HOP_CYCLES); // see [R16] see [R19]
			end else if (hop != 16'h0000) begin
				hop <= hop - 16'h0001;
				CHAIN_START_OUT <= (hop == 16'h0001);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register read port

	assign rd_idx = 4'((ADDR - cell_seq_pkg::RESULT_BASE) >> 2);

	// read data stands in the cycle after the strobe only; unmapped reads zero
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			RDATA <= 32'h0000_0000;
		end else begin
			RDATA <= 32'h0000_0000;
			if (RD) begin
				if (ADDR == cell_seq_pkg::CONTROL_ADDR) begin
					RDATA[cell_seq_pkg::SEL_HI:cell_seq_pkg::SEL_LO] <= ctrl.sel;
					RDATA[cell_seq_pkg::AVG_HI:cell_seq_pkg::AVG_LO] <= ctrl.avg;
					RDATA[cell_seq_pkg::ACQ_HI:cell_seq_pkg::ACQ_LO] <= ctrl.acq;
					RDATA[cell_seq_pkg::ARM_BIT] <= ctrl.arm;
				end else if (ADDR == cell_seq_pkg::STATUS_ADDR) begin
					RDATA[7:0] <= {MUX_SEL, SETTLING, READY, BUSY, ctrl.arm};
				end else if (ADDR == cell_seq_pkg::CHAIN_ADDR) begin
					RDATA[2:0] <= chain_above;
				end else if (ADDR >= cell_seq_pkg::RESULT_BASE && ADDR <= cell_seq_pkg::RESULT_LAST
					&& ADDR[1:0] == 2'h0) begin
					RDATA[DATA_W-1:0] <= result[rd_idx];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	logic [15:0] gap; // cycles since the last convert pulse
	logic seen_conv; // a convert pulse has occurred in this burst
	logic [7:0] conv_count; // convert pulses in this burst

	// helper counters for the checks below
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			gap <= 16'h0000;
			seen_conv <= 1'b0;
			conv_count <= 8'h00;
		end else begin
			gap <= CONVERT ? 16'h0001 : gap + 16'h0001;
			if (state == cell_seq_pkg::ST_IDLE) begin
				seen_conv <= 1'b0;
				conv_count <= 8'h00;
			end else if (CONVERT) begin
				seen_conv <= 1'b1;
				conv_count <= conv_count + 8'h01;
			end
		end
	end

	chk_conv_one_pulse: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see [R3]
		CONVERT |=> !CONVERT ##1 !CONVERT) else $error("convert pulse too long or too close");
	chk_channel_min_time: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see [R4]
		(CONVERT && seen_conv) |-> (gap >= 16'(cell_seq_pkg::CHAN_MIN_CYC))) else $error("channel under 1 us");
	chk_pin_starts_burst: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see [R5]
		(state == cell_seq_pkg::ST_IDLE && pin_q && !CONV_START_N && ctrl.sel != cell_seq_pkg::SEL_SELFTEST)
		|=> CONVERT && BUSY) else $error("pin edge did not start a burst");
	chk_cells_only_end: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see [R6]
		(ctrl.sel == cell_seq_pkg::SEL_CELLS && state == cell_seq_pkg::ST_CONV && timer == 16'h0000
		&& last_rep && MUX_SEL == cell_seq_pkg::CH_LAST_CELL) |=> state == cell_seq_pkg::ST_WAIT)
		else $error("cells-only burst did not stop after six");
	chk_order_all: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see [R2]
		($rose(ACQUIRE) && ctrl.sel == cell_seq_pkg::SEL_ALL && state == cell_seq_pkg::ST_ACQ && rep == 3'h0)
		|-> MUX_SEL == $past(MUX_SEL) + 4'h1) else $error("channel order broken");
	chk_repeat_same: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see [R13]
		($rose(ACQUIRE) && rep != 3'h0) |-> $stable(MUX_SEL)) else $error("mux moved before repeats done");
	chk_ready_after_wait: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see [R9]
		(state == cell_seq_pkg::ST_CONV && timer == 16'h0000 && last_rep && nxt_ch == cell_seq_pkg::CH_DONE)
		|=> !READY [*8]) else $error("results released before resync wait");
	chk_ready_on_done: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see [R10]
		$fell(BUSY) |-> READY && state == cell_seq_pkg::ST_IDLE) else $error("burst ended without ready");
	chk_forward_hop: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see [R16]
		(start_take && chain_above != 3'h0) |-> ##[1:1000] CHAIN_START_OUT) else $error("start not forwarded");
	chk_burst_count: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see [R18]
		CONVERT |-> conv_count < 8'(12 * 8)) else $error("too many conversions in a burst");
	chk_busy_ignores: assert property (@(posedge CORE_CLK) disable iff (!RESET_N) // see [R20]
		(state == cell_seq_pkg::ST_ACQ && start_req && timer != 16'h0000) |=> !CONVERT)
		else $error("start accepted during a burst");

endmodule

// ==== verification/adc_front_model.sv ====
// behavioural converter front end feeding predictable samples to the sequencer
`timescale 1ns/100ps
module adc_front_model (
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	input wire logic CONVERT,
	input wire logic [3:0] MUX_SEL,
	output logic [11:0] ADC_DATA
);
	////////////////
	logic [3:0] last_ch; // channel of the previous conversion
	logic [2:0] rep; // repeat index on the current channel
	// repeat index restarts on a new channel, so an average is known in advance
	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			last_ch <= 4'hf;
			rep <= 3'h0;
		end else if (CONVERT) begin
			last_ch <= MUX_SEL;
			rep <= (MUX_SEL == last_ch) ? rep + 3'h1 : 3'h0;
		end
	end
	// sample word carries the channel in its top bits and the repeat index below
	assign ADC_DATA = {MUX_SEL, 5'h00, rep};
endmodule

// ==== verification/tb.sv ====
// self-checking bench for the cell conversion sequencer
`timescale 1ns/100ps
module tb;
	////////////////
	localparam int HOP = 3; // short hop delay for simulation
	localparam int LIMIT = 30000; // hang ceiling in cycles
	typedef logic [3:0] chq_t[$];
	typedef struct {logic [1:0] sel; logic [1:0] avg; logic [1:0] acq; int n;} row_t;
	logic CORE_CLK = 1'b0; // 50 MHz core clock
	logic RESET_N = 1'b0;
	logic [7:0] ADDR = 8'h00;
	logic [31:0] WDATA = 32'h0;
	logic WR = 1'b0;
	logic RD = 1'b0;
	logic CONV_START_N = 1'b1; // idle high, falling edge starts
	logic CS_N = 1'b1;
	logic CHAIN_START_IN = 1'b0;
	logic [31:0] RDATA;
	logic [11:0] ADC_DATA;
	logic [3:0] MUX_SEL;
	logic CHAIN_START_OUT, ACQUIRE, CONVERT, BUSY, READY, SETTLING;
	int mismatches = 0;
	int compares = 0;
	int cycle = 0; // free-running cycle count
	int chain_at = -1; // cycle of the last forwarded start
	int chain_n = 0; // forwarded starts seen
	logic [3:0] seen[$]; // channel at each conversion pulse
	int stamp[$]; // cycle of each conversion pulse
	// select, average, acquire, expected conversion count
	row_t rows[6] = '{'{2'h0, 2'h0, 2'h0, 12}, '{2'h1, 2'h0, 2'h1, 9}, '{2'h2, 2'h0, 2'h2, 6},
		'{2'h3, 2'h0, 2'h3, 1}, '{2'h0, 2'h1, 2'h0, 24}, '{2'h2, 2'h3, 2'h0, 48}};
	////////////////
	always #10 CORE_CLK = ~CORE_CLK;
	cell_conversion_sequencer #(.SETTLE_CYCLES(20), .HOP_CYCLES(HOP)) dut_u (.CORE_CLK(CORE_CLK),
		.RESET_N(RESET_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
		.CONV_START_N(CONV_START_N), .CS_N(CS_N), .CHAIN_START_IN(CHAIN_START_IN),
		.CHAIN_START_OUT(CHAIN_START_OUT), .ADC_DATA(ADC_DATA), .MUX_SEL(MUX_SEL), .ACQUIRE(ACQUIRE),
		.CONVERT(CONVERT), .BUSY(BUSY), .READY(READY), .SETTLING(SETTLING));
	adc_front_model adc_u (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .CONVERT(CONVERT), .MUX_SEL(MUX_SEL),
		.ADC_DATA(ADC_DATA));
	////////////////
	// logs conversion pulses and forwarded starts, and cuts a hang short
	always @(posedge CORE_CLK) begin
		cycle <= cycle + 1;
		if (CONVERT === 1'b1) begin
			seen.push_back(MUX_SEL);
			stamp.push_back(cycle);
		end
		if (CHAIN_START_OUT === 1'b1) begin
			chain_at <= cycle;
			chain_n <= chain_n + 1;
		end
		if (cycle == LIMIT) begin
			mismatches++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// bus write: one strobe cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CORE_CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CORE_CLK);
		WR <= 1'b0;
	endtask
	// bus read: data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge CORE_CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CORE_CLK);
		RD <= 1'b0;
		#1 d = RDATA;
	endtask
	// bounded wait for ready (rdy set) or for settling to end
	task automatic wait_until(input bit rdy);
		int k;
		for (k = 0; k < 5000; k++) begin
			@(posedge CORE_CLK);
			#1;
			if (rdy ? READY === 1'b1 : SETTLING === 1'b0) break;
		end
	endtask
	task automatic pin_start();
		@(posedge CORE_CLK);
		CONV_START_N <= 1'b0;
		repeat (2) @(posedge CORE_CLK);
		CONV_START_N <= 1'b1;
	endtask
	// writes the control word, waits out the settle time, clears the log
	task automatic setup(input row_t r, input logic arm);
		wr(8'h00, {16'h0, r.sel, 3'h0, r.avg, 2'h0, r.acq, 3'h0, arm, 1'b0});
		wait_until(1'b0);
		seen.delete();
		stamp.delete();
	endtask
	// cells first from the top, then odd, all or no aux, or the self-test slot alone
	function automatic chq_t chans_of(input logic [1:0] sel);
		chq_t q;
		int c;
		if (sel == 2'h3) begin
			q.push_back(4'hc);
			return q;
		end
		for (c = 0; c < 12; c++) begin
			if (c < 6 || sel == 2'h0 || (sel == 2'h1 && c % 2 == 0)) q.push_back(c[3:0]);
		end
		return q;
	endfunction
	task automatic run_row(input row_t r);
		chq_t chans;
		logic [31:0] d;
		int k;
		int j;
		chans = chans_of(r.sel);
		setup(r, 1'b0);
		pin_start();
		wait_until(1'b1);
		chk(seen.size(), r.n);
		k = 0;
		foreach (chans[i]) begin
			for (j = 0; j < (1 << r.avg); j++) begin
				chk(seen[k], chans[i]);
				k++;
			end
			rd(8'h10 + {chans[i], 2'b00}, d);
			chk(d, {20'h0, chans[i], 5'h00, 3'((2 ** r.avg - 1) / 2)});
		end
		if (r.n > 1) chk(stamp[r.n - 1] - stamp[0], (r.n - 1) * (30 + 20 * (r.acq + 1)));
		rd(8'h04, d);
		chk(d[7:0], 8'h04);
	endtask
	////////////////
	initial begin
		logic [31:0] d;
		int t0;
		int n0;
		repeat (16) @(posedge CORE_CLK);
		RESET_N <= 1'b1;
		rd(8'h00, d);
		chk(d, 32'h0);
		rd(8'h0c, d);
		chk(d, 32'h0);
		// idle outputs: mux rests on the top cell and acquires, nothing pending
		chk({23'h0, MUX_SEL, ACQUIRE, BUSY, READY, SETTLING, CHAIN_START_OUT}, 32'h10);
		$display("reset test done");
		foreach (rows[i]) begin
			run_row(rows[i]);
			$display("row %0d done", i);
		end
		// a second start in mid-burst leaves no trace; timed to land in an acquire phase
		setup(rows[0], 1'b0);
		pin_start();
		repeat (80) @(posedge CORE_CLK);
		chk({30'h0, BUSY, ACQUIRE}, 32'h3);
		pin_start();
		wait_until(1'b1);
		repeat (100) @(posedge CORE_CLK);
		chk(seen.size(), 12);
		$display("refusal test done");
		// armed chip-select rise starts once; the arm is then spent
		setup(rows[0], 1'b1);
		@(posedge CORE_CLK);
		CS_N <= 1'b0;
		@(posedge CORE_CLK);
		CS_N <= 1'b1;
		wait_until(1'b1);
		chk(seen.size(), 12);
		seen.delete();
		@(posedge CORE_CLK);
		CS_N <= 1'b0;
		@(posedge CORE_CLK);
		CS_N <= 1'b1;
		repeat (100) @(posedge CORE_CLK);
		chk(seen.size(), 0);
		$display("chip-select test done");
		// full stack: start forwarded one hop later
		wr(8'h08, 32'h7);
		wait_until(1'b0);
		rd(8'h08, d);
		chk(d, 32'h7);
		@(posedge CORE_CLK);
		CHAIN_START_IN <= 1'b1;
		@(posedge CORE_CLK);
		t0 = cycle;
		CHAIN_START_IN <= 1'b0;
		wait_until(1'b1);
		// the pulse stands in the cycle after the hop count ends, so the log sees it one edge later
		chk(chain_at - t0, HOP + 1);
		wr(8'h08, 32'h0);
		wait_until(1'b0);
		n0 = chain_n;
		pin_start();
		wait_until(1'b1);
		chk(chain_n, n0);
		$display("chain test done");
		print_verdict();
	end
endmodule
